// File: hdl/agds_cfg.svh
// constants for the adaptive gate drive sequencer
`ifndef AGDS_CFG_SVH
`define AGDS_CFG_SVH
// clock period in ns (10 MHz)
`define AGDS_CLK_NS          100
// code width of the gate current
`define AGDS_CODE_W          6
// lowest pre-charge and pre-discharge current code
`define AGDS_MIN_CODE        6'h00
// highest current code
`define AGDS_TOP_CODE        6'h3F
// width of phase and delay counters
`define AGDS_CNT_W           10
// adaptive mode field values
`define AGDS_MODE_ADAPT_A    2'h2
`define AGDS_MODE_ADAPT_B    2'h3
// depth of the delay history kept per edge
`define AGDS_HIST_DEPTH      2
`endif

// File: hdl/agds_pkg.sv
// types for the adaptive gate drive sequencer
package agds_pkg;
  // sequencer phases
  typedef enum logic [3:0] {
    AGDS_IDLE_OFF  = 4'h0,
    AGDS_ON_CCP    = 4'h1,
    AGDS_PRECHG    = 4'h2,
    AGDS_CHG       = 4'h3,
    AGDS_POSTCHG   = 4'h4,
    AGDS_ON_HOLD   = 4'h5,
    AGDS_SYM       = 4'h6,
    AGDS_PREDCHG   = 4'h7,
    AGDS_DCHG      = 4'h8,
    AGDS_FW_ON     = 4'h9
  } agds_state_t;
  // gate drive command for one mosfet
  typedef struct packed {
    logic       on;     // gate is sourced
    logic       off;    // gate is sunk
    logic [5:0] code;   // current code
  } agds_gate_t;
endpackage

// File: hdl/agds_adapt.sv
// one adaptive current code with filter, step and clamp
`timescale 1ns/1ps
`include "agds_cfg.svh"
module agds_adapt #(
  parameter int CW = `AGDS_CODE_W
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  // configuration
  input  wire logic          i_load,      // enable rose: load initial value
  input  wire logic [CW-1:0] i_init,
  input  wire logic [CW-1:0] i_max,
  input  wire logic [CW-1:0] i_min,
  input  wire logic          i_adapt_en,
  input  wire logic          i_filter,
  input  wire logic          i_step2,
  // one measurement result per pwm cycle
  input  wire logic          i_meas_vld,
  input  wire logic          i_slow,      // delay above target
  input  wire logic          i_fast,      // delay below target
  // adapted code
  output logic      [CW-1:0] o_code
);
  logic [CW-1:0] code_q;   // adapted code
  logic [1:0]    prev_q;   // previous result: {slow, fast}
  logic          up;
  logic          dn;
  logic [CW:0]   stp;
  logic [CW:0]   sum;

  // clamp a wide value into [lo, hi]
  function automatic logic [CW-1:0] clamp(input logic [CW:0] v,
                                          input logic [CW-1:0] lo,
                                          input logic [CW-1:0] hi);
    if (v > {1'b0, hi})
      clamp = hi;
    else if (v < {1'b0, lo})
      clamp = lo;
    else
      clamp = v[CW-1:0];
  endfunction

  // direction decision: filtered needs two alike results
  always_comb begin
    up  = i_filter ? (i_slow && prev_q[1]) : i_slow;
    dn  = i_filter ? (i_fast && prev_q[0]) : i_fast;
    stp = i_step2 ? (CW+1)'(2) : (CW+1)'(1);
    if (up)
      sum = {1'b0, code_q} + stp;
    else if (dn && ({1'b0, code_q} >= stp))
      sum = {1'b0, code_q} - stp;
    else if (dn)
      sum = '0;
    else
      sum = {1'b0, code_q};
  end

  // code register; a fresh enable wins over a pending step
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      code_q <= `AGDS_MIN_CODE;
    else if (i_load)
      code_q <= (i_init < i_max) ? i_init : i_max;
    else if (i_meas_vld && i_adapt_en)
      code_q <= clamp(sum, i_min, i_max);
  end

  // history of the last result, cleared on enable
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_load)
      prev_q <= 2'h0;
    else if (i_meas_vld)
      prev_q <= {i_slow, i_fast};
  end

  assign o_code = code_q;
endmodule

// File: hdl/agds_seq.sv
// high-side pwm adaptive gate drive sequencer for one half-bridge
`timescale 1ns/1ps
`include "agds_cfg.svh"
module agds_seq #(
  parameter int CW = `AGDS_CODE_W,
  parameter int TW = `AGDS_CNT_W
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // synchronized pwm input
  input  wire logic                 i_pwm_input,
  // mode configuration
  input  wire logic                 i_halfbridge_pwm_enable,
  input  wire logic                 i_active_freewheel_select,
  input  wire logic [1:0]           i_adaptive_gate_mode,
  input  wire logic                 i_adaptation_filter_bit,
  input  wire logic                 i_adaptation_step_size_bit,
  // current codes
  input  wire logic [CW-1:0]        i_charge_current,
  input  wire logic [CW-1:0]        i_discharge_current,
  input  wire logic [CW-1:0]        i_freewheel_gate_current,
  input  wire logic [CW-1:0]        i_maximum_gate_current_code,
  input  wire logic [CW-1:0]        i_precharge_initial_value,
  input  wire logic [CW-1:0]        i_predischarge_initial_value,
  // times in clock cycles
  input  wire logic [TW-1:0]        i_freewheeling_cross_current_time,
  input  wire logic [TW-1:0]        i_active_cross_current_time,
  input  wire logic [TW-1:0]        i_precharge_duration,
  input  wire logic [TW-1:0]        i_predischarge_duration,
  input  wire logic [TW-1:0]        i_drain_source_filter_time,
  input  wire logic [TW-1:0]        i_turn_on_delay,
  input  wire logic [TW-1:0]        i_turn_off_delay,
  // switch node comparators
  input  wire logic                 i_switch_node_high_threshold,
  input  wire logic                 i_switch_node_low_threshold,
  // gate commands
  output agds_pkg::agds_gate_t      o_high_gate,
  output agds_pkg::agds_gate_t      o_low_gate,
  // status
  output agds_pkg::agds_state_t     o_phase,
  output logic [TW-1:0]             o_eff_turn_on_delay,
  output logic [TW-1:0]             o_eff_turn_off_delay
);
  // ****************************************
  // declarations
  // ****************************************
  agds_pkg::agds_state_t st_q;           // sequencer phase
  agds_pkg::agds_gate_t  hs_q;           // high-side command
  agds_pkg::agds_gate_t  ls_q;           // low-side command
  logic [TW-1:0]         ph_cnt_q;       // time in current phase
  logic [TW-1:0]         ccp_cnt_q;      // active ccp time, runs alongside turn-off
  logic                  ccp_run_q;      // active ccp window open
  logic [TW-1:0]         flt_cnt_q;      // drain-source filter time
  logic [TW-1:0]         dly_cnt_q;      // delay measure counter
  logic [TW-1:0]         eon_q;          // last effective turn-on delay
  logic [TW-1:0]         eoff_q;         // last effective turn-off delay
  logic                  pwm_q;          // previous pwm level
  logic                  en_q;           // previous enable level
  logic                  on_vld_q;       // one turn-on measurement ready
  logic                  off_vld_q;      // one turn-off measurement ready
  logic                  fw_q;           // fw charge still allowed
  logic                  ccp_end;        // last cycle of the active ccp time, or ccp window not open
  logic                  rise;
  logic                  fall;
  logic                  en_rise;
  logic                  adapt_en;
  logic [CW-1:0]         pre_code;
  logic [CW-1:0]         pred_code;

  // ****************************************
  // edge detection and mode decode
  // ****************************************
  assign rise     = i_pwm_input && !pwm_q;
  assign fall     = !i_pwm_input && pwm_q;
  assign en_rise  = i_halfbridge_pwm_enable && !en_q;
  assign adapt_en = (i_adaptive_gate_mode == `AGDS_MODE_ADAPT_A) ||
                    (i_adaptive_gate_mode == `AGDS_MODE_ADAPT_B);
  assign ccp_end  = !ccp_run_q || (ccp_cnt_q + TW'(1) >= i_active_cross_current_time);

  // past levels for edge detection
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pwm_q <= 1'b0;
      en_q  <= 1'b0;
    end else begin
      pwm_q <= i_pwm_input;
      en_q  <= i_halfbridge_pwm_enable;
    end
  end

  // ****************************************
  // phase sequencer
  // ****************************************
  // a pwm edge mid-sequence restarts the opposite sequence at once,
  // so a narrow pulse is never stretched by a pending phase
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_halfbridge_pwm_enable) begin
      st_q     <= agds_pkg::AGDS_IDLE_OFF;
      ph_cnt_q <= '0;
    end else if (rise) begin
      ph_cnt_q <= '0;
      if (i_active_freewheel_select)
        st_q <= agds_pkg::AGDS_ON_CCP;
      else
        st_q <= agds_pkg::AGDS_PRECHG;
    end else if (fall) begin
      ph_cnt_q <= '0;
      if (i_active_freewheel_select)
        st_q <= agds_pkg::AGDS_SYM;
      else
        st_q <= agds_pkg::AGDS_PREDCHG;
    end else begin
      ph_cnt_q <= ph_cnt_q + TW'(1);
      unique case (st_q)
        agds_pkg::AGDS_IDLE_OFF: ph_cnt_q <= '0;
        agds_pkg::AGDS_ON_CCP:
          if (ph_cnt_q + TW'(1) >= i_freewheeling_cross_current_time) begin
            st_q     <= agds_pkg::AGDS_PRECHG;
            ph_cnt_q <= '0;
          end
        agds_pkg::AGDS_PRECHG:
          if (ph_cnt_q + TW'(1) >= i_precharge_duration) begin
            st_q     <= agds_pkg::AGDS_CHG;
            ph_cnt_q <= '0;
          end
        agds_pkg::AGDS_CHG:
          if (i_switch_node_high_threshold) begin
            st_q     <= agds_pkg::AGDS_POSTCHG;
            ph_cnt_q <= '0;
          end
        agds_pkg::AGDS_POSTCHG:
          if (ph_cnt_q + TW'(1) >= i_drain_source_filter_time) begin
            st_q     <= agds_pkg::AGDS_ON_HOLD;
            ph_cnt_q <= '0;
          end
        agds_pkg::AGDS_ON_HOLD: ph_cnt_q <= '0;
        agds_pkg::AGDS_SYM:
          if (ph_cnt_q + TW'(1) >= i_freewheeling_cross_current_time) begin
            st_q     <= agds_pkg::AGDS_PREDCHG;
            ph_cnt_q <= '0;
          end
        agds_pkg::AGDS_PREDCHG:
          if (ph_cnt_q + TW'(1) >= i_predischarge_duration) begin
            st_q     <= agds_pkg::AGDS_DCHG;
            ph_cnt_q <= '0;
          end
        agds_pkg::AGDS_DCHG:
          if (ccp_end) begin
            st_q     <= agds_pkg::AGDS_FW_ON;
            ph_cnt_q <= '0;
          end
        agds_pkg::AGDS_FW_ON: ph_cnt_q <= '0;
        default: st_q <= agds_pkg::AGDS_IDLE_OFF;
      endcase
    end
  end

  // ****************************************
  // active cross-current window
  // ****************************************
  // runs from the end of symmetrization, or from the pwm fall in passive mode, concurrent with pre-discharge;
  // the host keeps pre-discharge shorter so discharge is always reached
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || rise || !i_halfbridge_pwm_enable) begin
      ccp_run_q <= 1'b0;
      ccp_cnt_q <= '0;
    end else if (st_q != agds_pkg::AGDS_PREDCHG && (st_q == agds_pkg::AGDS_SYM &&
                 ph_cnt_q + TW'(1) >= i_freewheeling_cross_current_time ||
                 fall && !i_active_freewheel_select)) begin
      ccp_run_q <= 1'b1;
      ccp_cnt_q <= '0;
    end else if (ccp_run_q) begin
      ccp_cnt_q <= ccp_cnt_q + TW'(1);
      if (ccp_cnt_q + TW'(1) >= i_active_cross_current_time)
        ccp_run_q <= 1'b0;
    end
  end

  // ****************************************
  // drain-source filter timer after turn-off
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || st_q != agds_pkg::AGDS_FW_ON)
      flt_cnt_q <= '0;
    else if (flt_cnt_q != i_drain_source_filter_time)
      flt_cnt_q <= flt_cnt_q + TW'(1);
  end

  // fw charge is allowed only while the switch node stays low
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || st_q != agds_pkg::AGDS_FW_ON)
      fw_q <= 1'b1;
    else if (!i_switch_node_low_threshold)
      fw_q <= 1'b0;
  end

  // ****************************************
  // delay measurement
  // ****************************************
  // turn-on delay runs from pre-charge start to high threshold,
  // turn-off delay from pre-discharge start to discharge end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dly_cnt_q <= '0;
      eon_q     <= '0;
      eoff_q    <= '0;
      on_vld_q  <= 1'b0;
      off_vld_q <= 1'b0;
    end else begin
      on_vld_q  <= 1'b0;
      off_vld_q <= 1'b0;
      if (st_q inside {agds_pkg::AGDS_PRECHG, agds_pkg::AGDS_PREDCHG, agds_pkg::AGDS_DCHG} ||
          (st_q == agds_pkg::AGDS_CHG && !i_switch_node_high_threshold))
        dly_cnt_q <= (dly_cnt_q == '1) ? dly_cnt_q : dly_cnt_q + TW'(1);
      else
        dly_cnt_q <= '0;
      if (st_q == agds_pkg::AGDS_CHG && i_switch_node_high_threshold &&
          !rise && !fall) begin
        eon_q    <= dly_cnt_q;
        on_vld_q <= 1'b1;
      end
      if (st_q == agds_pkg::AGDS_DCHG && ccp_end && !rise && !fall) begin
        eoff_q    <= dly_cnt_q + TW'(1);
        off_vld_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // adaptive codes
  // ****************************************
  agds_adapt #(.CW(CW)) u_pre (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_load     (en_rise),
    .i_init     (i_precharge_initial_value),
    .i_max      (i_maximum_gate_current_code),
    .i_min      (`AGDS_MIN_CODE),
    .i_adapt_en (adapt_en),
    .i_filter   (i_adaptation_filter_bit),
    .i_step2    (i_adaptation_step_size_bit),
    .i_meas_vld (on_vld_q),
    .i_slow     (eon_q > i_turn_on_delay),
    .i_fast     (eon_q < i_turn_on_delay),
    .o_code     (pre_code)
  );

  agds_adapt #(.CW(CW)) u_pred (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_load     (en_rise),
    .i_init     (i_predischarge_initial_value),
    .i_max      (i_maximum_gate_current_code),
    .i_min      (`AGDS_MIN_CODE),
    .i_adapt_en (adapt_en),
    .i_filter   (i_adaptation_filter_bit),
    .i_step2    (i_adaptation_step_size_bit),
    .i_meas_vld (off_vld_q),
    .i_slow     (eoff_q > i_turn_off_delay),
    .i_fast     (eoff_q < i_turn_off_delay),
    .o_code     (pred_code)
  );

  // ****************************************
  // high-side gate command
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hs_q <= '{on: 1'b0, off: 1'b1, code: `AGDS_MIN_CODE};
    end else begin
      unique case (st_q)
        agds_pkg::AGDS_PRECHG:
          hs_q <= '{on: 1'b1, off: 1'b0, code: pre_code};
        agds_pkg::AGDS_CHG:
          hs_q <= '{on: 1'b1, off: 1'b0, code: i_charge_current};
        agds_pkg::AGDS_POSTCHG, agds_pkg::AGDS_ON_HOLD:
          if (hs_q.code < i_maximum_gate_current_code)
            hs_q.code <= hs_q.code + CW'(1);
        agds_pkg::AGDS_SYM:
          hs_q <= hs_q;
        agds_pkg::AGDS_PREDCHG:
          hs_q <= '{on: 1'b0, off: 1'b1, code: pred_code};
        agds_pkg::AGDS_DCHG:
          hs_q <= '{on: 1'b0, off: 1'b1, code: i_discharge_current};
        default:
          hs_q <= '{on: 1'b0, off: 1'b1, code: i_discharge_current};
      endcase
    end
  end

  // ****************************************
  // low-side gate command
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_active_freewheel_select) begin
      ls_q <= '{on: 1'b0, off: 1'b1, code: `AGDS_MIN_CODE};
    end else if (st_q == agds_pkg::AGDS_ON_CCP) begin
      ls_q <= '{on: 1'b0, off: 1'b1, code: i_freewheel_gate_current};
    end else if (st_q == agds_pkg::AGDS_FW_ON && fw_q && i_switch_node_low_threshold &&
                 flt_cnt_q != i_drain_source_filter_time) begin
      ls_q <= '{on: 1'b1, off: 1'b0, code: i_freewheel_gate_current};
    end else if (st_q != agds_pkg::AGDS_FW_ON || !ls_q.on) begin  // a running fw charge holds
      ls_q <= '{on: 1'b0, off: 1'b1, code: ls_q.code};
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_high_gate          = hs_q;
  assign o_low_gate           = ls_q;
  assign o_phase              = st_q;
  assign o_eff_turn_on_delay  = eon_q;
  assign o_eff_turn_off_delay = eoff_q;
endmodule

// File: bench/agds_seq_asserts.sv
// port checker for the adaptive gate drive sequencer
`timescale 1ns/1ps
`include "agds_cfg.svh"
module agds_seq_asserts #(
  parameter int CW = `AGDS_CODE_W,
  parameter int TW = `AGDS_CNT_W
) (
  // clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_sys_rst,
  // configuration
  input wire logic                  i_active_freewheel_select,
  input wire logic [CW-1:0]         i_charge_current,
  input wire logic [CW-1:0]         i_discharge_current,
  input wire logic [CW-1:0]         i_freewheel_gate_current,
  input wire logic [CW-1:0]         i_maximum_gate_current_code,
  input wire logic [TW-1:0]         i_freewheeling_cross_current_time,
  input wire logic [TW-1:0]         i_active_cross_current_time,
  input wire logic [TW-1:0]         i_precharge_duration,
  input wire logic [TW-1:0]         i_predischarge_duration,
  input wire logic                  i_switch_node_low_threshold,
  // sequencer outputs
  input wire agds_pkg::agds_gate_t  o_high_gate,
  input wire agds_pkg::agds_gate_t  o_low_gate,
  input wire agds_pkg::agds_state_t o_phase
);
  // ********
  // helpers
  // ********
  agds_pkg::agds_state_t ph_q;  // phase one sample back
  logic [TW-1:0]         run_q; // samples spent in the phase
  logic [TW-1:0]         win_q; // samples in pre-discharge and discharge
  // run length, so phase durations can be tied to their inputs
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ph_q  <= agds_pkg::AGDS_IDLE_OFF;
      run_q <= '0;
    end else begin
      ph_q  <= o_phase;
      run_q <= (o_phase == ph_q) ? run_q + 1'b1 : TW'(1);
    end
  end
  // cross-current window spans both turn-off drive phases
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !(o_phase inside {agds_pkg::AGDS_PREDCHG, agds_pkg::AGDS_DCHG}))
      win_q <= '0;
    else
      win_q <= win_q + 1'b1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // reset check needs the reset itself, so it overrides the default disable
  rst_idle_a: assert property (disable iff (1'b0) i_sys_rst |=> o_phase == agds_pkg::AGDS_IDLE_OFF
    && !o_high_gate.on && o_high_gate.off && !o_low_gate.on) else $error("not idle after reset");
  ccp_low_sink_a: assert property (o_phase == agds_pkg::AGDS_ON_CCP |=> o_low_gate.off
    && o_low_gate.code == i_freewheel_gate_current && !o_high_gate.on) else $error("ccp drive");
  ccp_len_a: assert property ($past(o_phase) == agds_pkg::AGDS_ON_CCP
    && o_phase == agds_pkg::AGDS_PRECHG |-> run_q == i_freewheeling_cross_current_time)
    else $error("ccp length");
  pre_len_a: assert property ($past(o_phase) == agds_pkg::AGDS_PRECHG
    && o_phase == agds_pkg::AGDS_CHG |-> run_q == i_precharge_duration) else $error("pre length");
  pre_code_a: assert property (o_phase == agds_pkg::AGDS_PRECHG |=> o_high_gate.on
    && o_high_gate.code <= i_maximum_gate_current_code) else $error("pre-charge code");
  chg_code_a: assert property (o_phase == agds_pkg::AGDS_CHG |=> o_high_gate.on
    && o_high_gate.code == i_charge_current) else $error("charge code");
  post_ramp_a: assert property ($past(o_phase) == agds_pkg::AGDS_POSTCHG
    && o_phase == agds_pkg::AGDS_POSTCHG |=> o_high_gate.code == (($past(o_high_gate.code)
    < i_maximum_gate_current_code) ? $past(o_high_gate.code) + 1'b1
    : i_maximum_gate_current_code)) else $error("post-charge ramp");
  sym_len_a: assert property ($past(o_phase) == agds_pkg::AGDS_SYM
    && o_phase == agds_pkg::AGDS_PREDCHG |-> run_q == i_freewheeling_cross_current_time)
    else $error("symmetry delay");
  pred_len_a: assert property ($past(o_phase) == agds_pkg::AGDS_PREDCHG
    && o_phase == agds_pkg::AGDS_DCHG |-> run_q == i_predischarge_duration) else $error("pred len");
  pred_code_a: assert property (o_phase == agds_pkg::AGDS_PREDCHG |=> o_high_gate.off
    && !o_high_gate.on && o_high_gate.code <= i_maximum_gate_current_code) else $error("pred code");
  dchg_code_a: assert property (o_phase == agds_pkg::AGDS_DCHG |=> o_high_gate.off
    && o_high_gate.code == i_discharge_current) else $error("discharge code");
  act_win_a: assert property ($past(o_phase) == agds_pkg::AGDS_DCHG
    && o_phase == agds_pkg::AGDS_FW_ON |-> win_q == i_active_cross_current_time)
    else $error("active ccp window");
  low_off_a: assert property (o_phase inside {agds_pkg::AGDS_SYM, agds_pkg::AGDS_PREDCHG,
    agds_pkg::AGDS_DCHG} |=> !o_low_gate.on) else $error("low side on in ccp");
  fw_charge_a: assert property (i_active_freewheel_select && ph_q != agds_pkg::AGDS_FW_ON
    && o_phase == agds_pkg::AGDS_FW_ON && i_switch_node_low_threshold |=> o_low_gate.on
    && o_low_gate.code == i_freewheel_gate_current) else $error("free-wheel charge");
  passive_a: assert property (!i_active_freewheel_select && !$past(i_active_freewheel_select)
    |-> o_phase != agds_pkg::AGDS_ON_CCP && o_phase != agds_pkg::AGDS_SYM && !o_low_gate.on)
    else $error("passive mode drive");
  // main scenarios
  cover property (o_phase == agds_pkg::AGDS_POSTCHG);
  cover property (o_phase == agds_pkg::AGDS_FW_ON);
  cover property (!i_active_freewheel_select && o_phase == agds_pkg::AGDS_PRECHG);
endmodule
bind agds_seq agds_seq_asserts #(.CW(CW), .TW(TW)) chk_u (
  .i_clk, .i_sys_rst, .i_active_freewheel_select, .i_charge_current, .i_discharge_current,
  .i_freewheel_gate_current, .i_maximum_gate_current_code, .i_freewheeling_cross_current_time,
  .i_active_cross_current_time, .i_precharge_duration, .i_predischarge_duration,
  .i_switch_node_low_threshold, .o_high_gate, .o_low_gate, .o_phase
);

// File: bench/agds_fet_model.sv
// behavioural half-bridge switch node driven by the high-side gate
`timescale 1ns/1ps
module agds_fet_model (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // gate command and switching speed
  input  wire agds_pkg::agds_gate_t i_high_gate,
  input  wire logic [3:0]           i_rise_dly,  // at least one
  input  wire logic [3:0]           i_fall_dly,  // at least one
  // comparators
  output logic                      o_above_high,
  output logic                      o_below_low
);
  // ********
  // node lag
  // ********
  logic [3:0] on_q;   // clocks since the gate was sourced
  logic [3:0] off_q;  // clocks since the gate stopped sourcing
  // the node lags the gate, so a slow setting stretches the delay
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_high_gate.on)
      on_q <= '0;
    else if (on_q != 4'hF)
      on_q <= on_q + 4'h1;
  end
  // falling node, free-wheel current pulls it below ground
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_high_gate.on)
      off_q <= '0;
    else if (off_q != 4'hF)
      off_q <= off_q + 4'h1;
  end
  assign o_above_high = (on_q >= i_rise_dly);
  assign o_below_low  = (off_q >= i_fall_dly);
endmodule

// File: bench/tb.sv
// self-checking bench for the adaptive gate drive sequencer
`timescale 1ns/1ps
module tb;
  // ********
  // signals
  // ********
  localparam logic [5:0] MAXC = 6'h08;  // pre-phase ceiling
  localparam logic [5:0] PCI  = 6'h0A;  // above the ceiling, so the load clamps
  localparam logic [5:0] PDI  = 6'h05;
  // per cycle: mode, filter, step, slow turn-on (turn-off is the opposite)
  localparam logic [54:0] SEQ = {5'b10001, 5'b10010, 5'b11010, 5'b11011, 5'b10100,
    5'b10100, 5'b01011, 5'b10010, 5'b10010, 5'b10010, 5'b10010};
  logic       i_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_pwm_input = 1'b0;
  logic       i_halfbridge_pwm_enable = 1'b0;
  logic       i_active_freewheel_select = 1'b1;
  logic [1:0] i_adaptive_gate_mode = 2'h2;
  logic       i_adaptation_filter_bit = 1'b0;
  logic       i_adaptation_step_size_bit = 1'b0;
  logic [5:0] i_charge_current = 6'h03;
  logic [5:0] i_discharge_current = 6'h04;
  logic [5:0] i_freewheel_gate_current = 6'h0C;
  logic [5:0] i_maximum_gate_current_code = MAXC;
  logic [5:0] i_precharge_initial_value = PCI;
  logic [5:0] i_predischarge_initial_value = PDI;
  logic [9:0] i_freewheeling_cross_current_time = 10'h003;
  logic [9:0] i_active_cross_current_time = 10'h006;
  logic [9:0] i_precharge_duration = 10'h002;
  logic [9:0] i_predischarge_duration = 10'h002;
  logic [9:0] i_drain_source_filter_time = 10'h004;
  logic [9:0] i_turn_on_delay = 10'h001;
  logic [9:0] i_turn_off_delay = 10'h001;
  logic       i_switch_node_high_threshold;
  logic       i_switch_node_low_threshold;
  logic [9:0] o_eff_turn_on_delay;
  logic [9:0] o_eff_turn_off_delay;
  logic [3:0] rise_dly = 4'h1;                  // switching speed of the model
  logic [5:0] pc_exp = (PCI < MAXC) ? PCI : MAXC; // expected pre-charge code
  logic [5:0] pd_exp = (PDI < MAXC) ? PDI : MAXC; // expected pre-discharge code
  logic       pdir = 1'b0;                      // previous turn-on result was slow
  int         error_cnt = 0;
  int         n_tests = 0;
  int         i;
  agds_pkg::agds_gate_t  o_high_gate;
  agds_pkg::agds_gate_t  o_low_gate;
  agds_pkg::agds_state_t o_phase;
  agds_seq dut_u (.*);
  agds_fet_model fet_u (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_high_gate  (o_high_gate),
    .i_rise_dly   (rise_dly),
    .i_fall_dly   (4'h3),
    .o_above_high (i_switch_node_high_threshold),
    .o_below_low  (i_switch_node_low_threshold)
  );
  // ********
  // tasks
  // ********
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  task automatic cmp(input string nm, input logic [9:0] exp, input logic [9:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // bounded wait, polled at the falling edge where outputs are settled
  task automatic wait_phase(input agds_pkg::agds_state_t s);
    for (int k = 0; k < 200 && o_phase !== s; k++) @(negedge i_clk);
    cmp("phase reached", 10'(s), 10'(o_phase));
  endtask
  // step toward the target, saturating at both ends of the code range
  function automatic logic [5:0] adapt(input logic [5:0] c, input logic up, input logic dn,
                                       input logic s2);
    logic [6:0] t;
    t = {1'b0, c} + (s2 ? 7'h02 : 7'h01);
    if (up) return (t > {1'b0, MAXC}) ? MAXC : t[5:0];
    if (dn) return (c < (s2 ? 6'h02 : 6'h01)) ? 6'h00 : c - (s2 ? 6'h02 : 6'h01);
    return c;
  endfunction
  // one pwm period; the first falling edge in charge still shows pre-charge drive
  task automatic run_cycle(input logic [4:0] e);
    logic [5:0] pc;
    logic [5:0] pd;
    @(negedge i_clk);
    {i_adaptive_gate_mode, i_adaptation_filter_bit, i_adaptation_step_size_bit} = e[4:1];
    i_turn_on_delay = e[0] ? 10'h001 : 10'h3FF;
    i_turn_off_delay = e[0] ? 10'h3FF : 10'h001;
    rise_dly = e[0] ? 4'h9 : 4'h1;
    i_charge_current = {3'h0, e[2:0]};
    i_discharge_current = {1'b0, e};
    i_freewheel_gate_current = {1'b0, ~e};
    i_precharge_duration = e[1] ? 10'h003 : 10'h002;
    i_predischarge_duration = e[2] ? 10'h001 : 10'h002;
    i_pwm_input = 1'b1;
    wait_phase(agds_pkg::AGDS_CHG);
    pc = o_high_gate.code;
    wait_phase(agds_pkg::AGDS_ON_HOLD);
    i_pwm_input = 1'b0;
    wait_phase(agds_pkg::AGDS_DCHG);
    pd = o_high_gate.code;
    repeat (40) @(negedge i_clk);
    cmp("turn-on delay", e[0] ? 10'h00A : i_precharge_duration, o_eff_turn_on_delay);
    cmp("turn-off delay", i_active_cross_current_time, o_eff_turn_off_delay);
    if (e[4]) begin
      cmp("pre-charge code", 10'(pc_exp), 10'(pc));
      cmp("pre-discharge code", 10'(pd_exp), 10'(pd));
      pc_exp = adapt(pc_exp, e[0] && (!e[2] || pdir), !e[0] && (!e[2] || !pdir), e[1]);
      pd_exp = adapt(pd_exp, !e[0] && (!e[2] || !pdir), e[0] && (!e[2] || pdir), e[1]);
    end
    pdir = e[0];
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ********
  // tests
  // ********
  initial begin
    repeat (4) @(negedge i_clk);
    cmp("reset phase", 10'h000, 10'(o_phase));
    cmp("reset high gate", 10'h040, {2'h0, o_high_gate});
    cmp("reset low gate", 10'h040, {2'h0, o_low_gate});
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    i_halfbridge_pwm_enable = 1'b1;
    for (i = 0; i < 11; i++) run_cycle(SEQ[50-5*i +: 5]);
    // an edge while disabled is refused, then passive mode after a fresh enable
    i_halfbridge_pwm_enable = 1'b0;
    i_active_freewheel_select = 1'b0;
    i_pwm_input = 1'b1;
    repeat (3) @(negedge i_clk);
    cmp("disabled phase", 10'h000, 10'(o_phase));
    i_pwm_input = 1'b0;
    @(negedge i_clk);
    i_halfbridge_pwm_enable = 1'b1;
    pc_exp = (PCI < MAXC) ? PCI : MAXC;
    pd_exp = (PDI < MAXC) ? PDI : MAXC;
    run_cycle(5'b10001);
    stop_test();
  end
  // watchdog well beyond twelve pwm periods
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    stop_test();
  end
endmodule
